// File: src/rbs_pkg.sv
// Package for the reset-time boot selection block.
// Assumes one core clock domain and an asynchronous active-high reset.
package rbs_pkg;

  // ****************************************
  // Security byte layout
  // ****************************************
  localparam int          SEC_DOUBLE_SPEED_BIT = 7;
  localparam int          SEC_BOOT_JUMP_BIT    = 6;
  localparam int          SEC_LOCK_HI          = 2;
  localparam int          SEC_LOCK_LO          = 0;
  localparam logic [7:0]  SEC_ERASED           = 8'hFF;
  localparam logic [7:0]  SEC_SW_MASK          = 8'hF0;
  localparam logic [7:0]  SEC_PAR_MASK         = 8'h0F;
  localparam logic [7:0]  SEC_DEFINED_MASK     = 8'hC7;

  // ****************************************
  // Flash control and start addresses
  // ****************************************
  localparam logic [7:0]  FLASH_CONTROL_REG_FORCED          = 8'h00;
  localparam logic [7:0]  FLASH_CONTROL_REG_NORMAL          = 8'hF0;
  localparam int          FLASH_CONTROL_REG_BUSY_BIT        = 0;
  localparam logic [15:0] ENTRY_USER           = 16'h0000;
  localparam logic [15:0] ENTRY_BOOT           = 16'hF800;
  localparam logic [7:0]  USER_VECTOR_ERASED   = 8'hFF;
  localparam logic [15:0] LOCK_ROLLOVER_LIMIT  = 16'h7FFF;

  // ****************************************
  // Extra row identification addresses
  // ****************************************
  localparam logic [7:0]  EXTRA_ROW_SPACE_MAKER_ADDR      = 8'h30;
  localparam logic [7:0]  EXTRA_ROW_SPACE_FAMILY_ADDR     = 8'h31;
  localparam logic [7:0]  EXTRA_ROW_SPACE_ID2_ADDR        = 8'h60;
  localparam logic [7:0]  EXTRA_ROW_SPACE_ID3_ADDR        = 8'h61;

  // ****************************************
  // Carriers and states
  // ****************************************
  typedef struct packed {
    logic program_store_strobe;
    logic external_access_pin;
    logic address_latch_strobe;
  } rbs_strap_s;

  typedef struct packed {
    logic        double_speed;
    logic        boot_rom_enable;
    logic        forced_boot;
    logic [15:0] start_addr;
    logic [7:0]  flash_control;
  } rbs_boot_s;

  typedef enum logic [2:0] {
    ST_RESET  = 3'b001,
    ST_DECIDE = 3'b010,
    ST_RUN    = 3'b100
  } rbs_state_e;

  function automatic logic [2:0] rbs_lock_level(input logic [2:0] lock_bits);
    // Programmed bit reads zero; the highest programmed bit wins
    if (!lock_bits[2]) begin
      return 3'h4;
    end else if (!lock_bits[1]) begin
      return 3'h3;
    end else if (!lock_bits[0]) begin
      return 3'h2;
    end
    return 3'h1;
  endfunction

endpackage

// File: src/rbs_strap_sync.sv
// Two-flop synchroniser for the three board strap pins.
// Assumes the pins are quasi-static around reset release.
`timescale 1ns/10ps
`default_nettype none
module rbs_strap_sync
  import rbs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire rbs_strap_s pins,
  output var  rbs_strap_s synced
);

  rbs_strap_s stage1;
  rbs_strap_s next_stage1;
  rbs_strap_s next_synced;

  always_comb begin
    next_stage1 = pins;
    next_synced = stage1;
  end

  // No reset: pins flow through while reset is held
  // Otherwise the decision would see reset levels, never a forced boot
  always_ff @(posedge core_clk) begin
    stage1 <= next_stage1;
    synced <= next_synced;
  end

endmodule
`default_nettype wire

// File: src/rbs_boot_select.sv
// Reset-time boot selection: strap sampling, security byte, start address.
// Assumes a parallel programmer port and a flash busy input from the array.
`timescale 1ns/10ps
`default_nettype none
module rbs_boot_select
  import rbs_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE  = 8'h11, // Arbitrary value
  parameter logic [7:0] FAMILY_CODE = 8'h22, // Arbitrary value
  parameter logic [7:0] DEVICE_ID2  = 8'h33, // Arbitrary value
  parameter logic [7:0] DEVICE_ID3  = 8'h44  // Arbitrary value
)(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire rbs_strap_s  strap_pins,
  input  wire logic        flash_busy_in,
  input  wire logic        chip_erase,
  input  wire logic        sw_sec_wr,
  input  wire logic [7:0]  sw_sec_wdata,
  input  wire logic        par_sec_wr,
  input  wire logic [7:0]  par_sec_wdata,
  input  wire logic        sw_vector_wr,
  input  wire logic [7:0]  sw_vector_wdata,
  input  wire logic        flash_control_reg_wr,
  input  wire logic [7:0]  flash_control_reg_wdata,
  input  wire logic [7:0]  extra_row_space_addr,
  output logic [7:0]       extra_row_space_rdata,
  output logic [7:0]       sw_sec_rdata,
  output logic [7:0]       par_sec_rdata,
  output logic [7:0]       user_boot_vector,
  output logic             user_loader_present,
  output logic [7:0]       flash_control_reg,
  output logic             boot_rom_enable,
  output logic             double_speed_select,
  output logic             forced_boot,
  output logic [15:0]      start_addr,
  output logic             boot_done,
  output logic [2:0]       lock_level,
  output logic             block_table_read,
  output logic             block_par_program,
  output logic             block_par_verify,
  output logic             block_rollover_exec
);

  // ****************************************
  // Strap synchroniser
  // ****************************************
  rbs_strap_s strap_sync;

  rbs_strap_sync u_sync (
    .core_clk (core_clk),
    .pins     (strap_pins),
    .synced   (strap_sync)
  );

  // ****************************************
  // Nonvolatile store and boot decision
  // ****************************************
  rbs_state_e  state;
  rbs_state_e  next_state;
  logic [7:0]  boot_security_fuse_byte;
  logic [7:0]  next_security;
  logic [7:0]  vector_q;
  logic [7:0]  next_vector;
  rbs_boot_s   boot_q;
  rbs_boot_s   next_boot;
  logic [7:0]  next_flash_control_reg;
  logic        boot_jump_select;
  logic        strap_force;
  logic [2:0]  next_level;

  assign boot_jump_select = boot_security_fuse_byte[SEC_BOOT_JUMP_BIT];
  assign strap_force = !strap_sync.program_store_strobe
                     && strap_sync.external_access_pin
                     && strap_sync.address_latch_strobe;

  always_comb begin
    next_state    = state;
    next_security = boot_security_fuse_byte;
    next_vector   = vector_q;
    next_boot     = boot_q;
    next_flash_control_reg     = flash_control_reg;
    unique case (state)
      ST_RESET: begin
        next_state = ST_DECIDE;
      end
      ST_DECIDE: begin
        next_state = ST_RUN;
        next_boot.boot_rom_enable = boot_jump_select;
        next_boot.double_speed = !boot_security_fuse_byte[SEC_DOUBLE_SPEED_BIT];
        next_boot.forced_boot = strap_force;
        if (strap_force) begin
          next_flash_control_reg             = FLASH_CONTROL_REG_FORCED;
          next_boot.start_addr  = ENTRY_BOOT;
        end else begin
          next_flash_control_reg             = FLASH_CONTROL_REG_NORMAL;
          next_boot.start_addr  = boot_jump_select ? ENTRY_USER : ENTRY_BOOT;
        end
      end
      ST_RUN: begin
        if (flash_control_reg_wr) begin
          next_flash_control_reg[7:1] = flash_control_reg_wdata[7:1];
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
    // Busy bit follows the array only; software data bit 0 is dropped
    next_flash_control_reg[FLASH_CONTROL_REG_BUSY_BIT] = flash_busy_in;
    if (sw_sec_wr) begin
      next_security = (boot_security_fuse_byte & SEC_PAR_MASK)
                    | (sw_sec_wdata & SEC_SW_MASK);
    end
    if (par_sec_wr && !block_par_program) begin
      next_security = par_sec_wdata;
    end
    if (sw_vector_wr) begin
      next_vector = sw_vector_wdata;
    end
    // Erase wins over any security or vector write in the same cycle
    if (chip_erase) begin
      next_security = SEC_ERASED;
      next_vector   = USER_VECTOR_ERASED;
    end
    next_boot.flash_control = next_flash_control_reg;
  end

  // Store is modelled as flops; erased values stand in for a blank part
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state                   <= ST_RESET;
      boot_security_fuse_byte <= SEC_ERASED;
      vector_q                <= USER_VECTOR_ERASED;
      boot_q                  <= '{1'b0, 1'b0, 1'b0, ENTRY_USER, FLASH_CONTROL_REG_FORCED};
      flash_control_reg       <= FLASH_CONTROL_REG_FORCED;
      user_loader_present     <= 1'b0;
      boot_done               <= 1'b0;
    end else begin
      state                   <= next_state;
      boot_security_fuse_byte <= next_security;
      vector_q                <= next_vector;
      boot_q                  <= next_boot;
      flash_control_reg       <= next_flash_control_reg;
      // Compared before the flop so both outputs leave a register
      user_loader_present     <= next_vector != USER_VECTOR_ERASED;
      boot_done               <= next_state == ST_RUN;
    end
  end

  // ****************************************
  // Read paths, identification and locks
  // ****************************************
  logic [7:0] next_extra_row_space;
  logic [7:0] next_sw_rd;
  logic [7:0] next_par_rd;

  always_comb begin
    unique case (extra_row_space_addr)
      EXTRA_ROW_SPACE_MAKER_ADDR:  next_extra_row_space = MAKER_CODE;
      EXTRA_ROW_SPACE_FAMILY_ADDR: next_extra_row_space = FAMILY_CODE;
      EXTRA_ROW_SPACE_ID2_ADDR:    next_extra_row_space = DEVICE_ID2;
      EXTRA_ROW_SPACE_ID3_ADDR:    next_extra_row_space = DEVICE_ID3;
      default:          next_extra_row_space = 8'h00;
    endcase
    // Undefined bits forced low so nothing downstream leans on them
    next_sw_rd  = next_security & SEC_SW_MASK & SEC_DEFINED_MASK;
    next_par_rd = next_security & SEC_DEFINED_MASK;
    next_level  = rbs_lock_level(next_security[SEC_LOCK_HI:SEC_LOCK_LO]);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      extra_row_space_rdata          <= 8'h00;
      sw_sec_rdata        <= 8'h00;
      par_sec_rdata       <= 8'h00;
      lock_level          <= 3'h1;
      block_table_read    <= 1'b0;
      block_par_program   <= 1'b0;
      block_par_verify    <= 1'b0;
      block_rollover_exec <= 1'b0;
    end else begin
      extra_row_space_rdata          <= next_extra_row_space;
      sw_sec_rdata        <= next_sw_rd;
      par_sec_rdata       <= next_par_rd;
      lock_level          <= next_level;
      block_table_read    <= next_level >= 3'h2;
      block_par_program   <= next_level >= 3'h2;
      block_par_verify    <= next_level >= 3'h3;
      block_rollover_exec <= next_level >= 3'h4;
    end
  end

  // Boot results stand until the next reset; user_boot_vector follows vector writes and erase
  assign user_boot_vector    = vector_q;
  assign boot_rom_enable     = boot_q.boot_rom_enable;
  assign double_speed_select = boot_q.double_speed;
  assign forced_boot         = boot_q.forced_boot;
  assign start_addr          = boot_q.start_addr;

endmodule
`default_nettype wire

// File: test/rbs_boot_select_monitor.sv
// Checker for boot selection: boot results, busy flag, security byte.
// Assumes one core clock domain; bound onto every boot selection instance.
`timescale 1ns/10ps
`default_nettype none
module rbs_boot_select_monitor
  import rbs_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        flash_busy_in,
  input wire logic        chip_erase,
  input wire logic        sw_sec_wr,
  input wire logic [7:0]  sw_sec_wdata,
  input wire logic        par_sec_wr,
  input wire logic [7:0]  sw_sec_rdata,
  input wire logic [7:0]  par_sec_rdata,
  input wire logic [7:0]  flash_control_reg,
  input wire logic        boot_rom_enable,
  input wire logic        forced_boot,
  input wire logic [15:0] start_addr,
  input wire logic        boot_done,
  input wire logic [2:0]  lock_level,
  input wire logic        block_rollover_exec
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Properties
  // ****************************************
  AST_BOOT_FLAG: assert property ($rose(boot_done) |-> boot_rom_enable == par_sec_rdata[6])
    else $error("boot rom enable wrong");
  AST_FORCED: assert property ($rose(boot_done) && forced_boot |->
    start_addr == ENTRY_BOOT && (flash_control_reg & 8'hFE) == FLASH_CONTROL_REG_FORCED) else $error("forced");
  AST_NORMAL: assert property ($rose(boot_done) && !forced_boot |->
    (flash_control_reg & 8'hFE) == FLASH_CONTROL_REG_NORMAL) else $error("normal flash_control_reg");
  AST_USER: assert property ($rose(boot_done) && !forced_boot && boot_rom_enable |->
    start_addr == ENTRY_USER) else $error("user start");
  AST_LOADER: assert property ($rose(boot_done) && !boot_rom_enable |->
    start_addr == ENTRY_BOOT) else $error("loader start");
  AST_BUSY: assert property (1'b1 |=> flash_control_reg[0] == $past(flash_busy_in))
    else $error("busy flag");
  // Lower nibble never reaches software
  AST_SW_WR: assert property (sw_sec_wr && !par_sec_wr && !chip_erase ##1
    !(sw_sec_wr || par_sec_wr || chip_erase) |=> sw_sec_rdata == ($past(sw_sec_wdata, 2) & 8'hC0))
    else $error("sw security");
  AST_ERASE: assert property (chip_erase ##1 !(sw_sec_wr || par_sec_wr) |=>
    par_sec_rdata == 8'hC7) else $error("erase");
  AST_LOCK4: assert property (!$past(sys_rst) && !par_sec_rdata[2] |->
    lock_level == 3'h4 && block_rollover_exec) else $error("lock level");
  cover property ($rose(boot_done) && forced_boot);
  cover property ($rose(boot_done) && !forced_boot && boot_rom_enable);
  cover property (chip_erase);
endmodule
bind rbs_boot_select rbs_boot_select_monitor mon_u (.core_clk, .sys_rst, .flash_busy_in,
  .chip_erase, .sw_sec_wr, .sw_sec_wdata, .par_sec_wr, .sw_sec_rdata, .par_sec_rdata,
  .flash_control_reg, .boot_rom_enable, .forced_boot, .start_addr, .boot_done, .lock_level,
  .block_rollover_exec);
`default_nettype wire

// File: test/rbs_board_model.sv
// Board model: reset circuit and strap pins.
// Assumes the bench steers it at the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module rbs_board_model
  import rbs_pkg::*;
(
  input  wire logic       rst_req,
  input  wire logic [2:0] level,
  input  wire logic       ale_float,
  output logic            sys_rst,
  output var rbs_strap_s  strap
);
  // Open latch strobe pin reads high through its pull-up
  assign strap = {level[2:1], level[0] | ale_float};
  assign sys_rst = rst_req;
endmodule
`default_nettype wire

// File: test/rbs_boot_select_tb_top.sv
// Testbench: boot rows in a table, then security, lock, erase, busy, extra row.
// Assumes the board model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module rbs_boot_select_tb_top
  import rbs_pkg::*;
;
  typedef struct packed {
    logic [2:0]  lv;
    logic        fl;
    logic [7:0]  sec;
    logic [15:0] sa;
    logic [7:0]  fc;
    logic [2:0]  ex;
  } rbs_row_s;
  rbs_row_s    rows [5] = '{
    '{3'b011, 1'b0, 8'hFF, 16'hF800, 8'h00, 3'b110},
    '{3'b010, 1'b1, 8'hBF, 16'hF800, 8'h00, 3'b100},
    '{3'b111, 1'b0, 8'hFF, 16'h0000, 8'hF0, 3'b010},
    '{3'b001, 1'b0, 8'hBF, 16'hF800, 8'hF0, 3'b000},
    '{3'b010, 1'b0, 8'h7F, 16'h0000, 8'hF0, 3'b011}};
  logic [7:0]  xadr [5] = '{8'h30, 8'h31, 8'h60, 8'h61, 8'h00};
  logic [7:0]  xexp [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00};
  logic        core_clk = 1'b0;
  logic        rst_req = 1'b1;
  logic        fl = 1'b0;
  logic        flash_busy_in = 1'b0;
  logic [2:0]  lv = 3'b111;
  logic [4:0]  stb = 5'h00;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  extra_row_space_addr = 8'h00;
  logic        sys_rst;
  rbs_strap_s  strap_pins;
  logic [7:0]  extra_row_space_rdata, sw_sec_rdata, par_sec_rdata, user_boot_vector, flash_control_reg;
  logic        user_loader_present, boot_rom_enable, double_speed_select, forced_boot, boot_done;
  logic        block_table_read, block_par_program, block_par_verify, block_rollover_exec;
  logic [15:0] start_addr;
  logic [2:0]  lock_level;
  int          errors = 0;
  int          cmp_count = 0;
  wire logic [6:0] lk = {lock_level, block_table_read, block_par_program, block_par_verify,
    block_rollover_exec};

  always #4 core_clk = ~core_clk;

  rbs_board_model brd_u (.rst_req, .level(lv), .ale_float(fl), .sys_rst, .strap(strap_pins));
  rbs_boot_select dut_u (.core_clk, .sys_rst, .strap_pins, .flash_busy_in,
    .chip_erase(stb[4]), .sw_sec_wr(stb[3]), .par_sec_wr(stb[2]), .sw_vector_wr(stb[1]),
    .flash_control_reg_wr(stb[0]), .sw_sec_wdata(wd), .par_sec_wdata(wd), .sw_vector_wdata(wd),
    .flash_control_reg_wdata(wd), .extra_row_space_addr, .extra_row_space_rdata, .sw_sec_rdata, .par_sec_rdata, .user_boot_vector,
    .user_loader_present, .flash_control_reg, .boot_rom_enable, .double_speed_select,
    .forced_boot, .start_addr, .boot_done, .lock_level, .block_table_read, .block_par_program,
    .block_par_verify, .block_rollover_exec);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Store and its read registers both move one edge after the write
  task automatic wr(input logic [4:0] s, input logic [7:0] d);
    stb = s;
    wd = d;
    cyc(1);
    stb = 5'h00;
    cyc(2);
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    foreach (rows[i]) begin
      lv = rows[i].lv;
      fl = rows[i].fl;
      rst_req = 1'b1;
      cyc(10);
      chk("reset state", 16'h0000, {7'h00, boot_done, flash_control_reg});
      stb = 5'h04;
      wd = rows[i].sec;
      rst_req = 1'b0;
      cyc(1);
      stb = 5'h00;
      cyc(4);
      chk("start", rows[i].sa, start_addr);
      chk("flash_control_reg", {8'h00, rows[i].fc}, {8'h00, flash_control_reg});
      chk("flags", {12'h001, rows[i].ex}, {12'h000, boot_done, forced_boot, boot_rom_enable,
        double_speed_select});
      $display("row %0d done", i);
    end
    wr(5'h08, 8'h5F);
    chk("sw read", 16'h0040, {8'h00, sw_sec_rdata});
    chk("par read", 16'h0047, {8'h00, par_sec_rdata});
    wr(5'h04, 8'hFB);
    chk("lock", 16'h004F, {9'h000, lk});
    wr(5'h04, 8'hFF);
    chk("par locked", 16'h00C3, {8'h00, par_sec_rdata});
    wr(5'h02, 8'h20);
    chk("vector", 16'h0120, {7'h00, user_loader_present, user_boot_vector});
    wr(5'h10, 8'h00);
    chk("erase", 16'h00C7, {8'h00, par_sec_rdata});
    chk("vector", 16'h00FF, {7'h00, user_loader_present, user_boot_vector});
    chk("lock", 16'h0010, {9'h000, lk});
    flash_busy_in = 1'b1;
    wr(5'h01, 8'h00);
    chk("busy", 16'h0001, {8'h00, flash_control_reg});
    foreach (xadr[k]) begin
      extra_row_space_addr = xadr[k];
      cyc(2);
      chk("extra_row_space", {8'h00, xexp[k]}, {8'h00, extra_row_space_rdata});
    end
    $display("hand tests done");
    results();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    results();
  end
endmodule
`default_nettype wire
